// ### src/unb_nine_bit.sv
// nine-bit multidrop addressing extension of the uart
// assumes a tx fifo with valid/pop, a tx shifter with ready, a receiver
// delivering one character per pulse, and a simple register port
//
// How it works
// - address character low byte compared to station
// - after match, data characters accepted until another address
// - station filter needs filter and nine-bit enable
// - address trigger sends ninth-bit-one station character
// - trigger self-clears when address enters holding stage
// - nine-bit write mode sends written ninth bit
// - nine-bit write mode ignores transmit station
// - eight-bit write mode: addresses only from station
// - eight-bit write mode, trigger low: ninth bit zero, byte from fifo
// - trigger acts only nine-bit, eight-bit write mode
// - filtering discards until matching address arrives
// - no filtering: every character goes to fifo
// - filter enable needs nine-bit enable
// - nine-bit enable sets nine-bit characters both ways
`include "unb_params.svh"
module unb_nine_bit
(
  input  wire logic               clk,
  input  wire logic               nrst,
  // register port
  input  wire logic               regWrEn,
  input  wire logic               regRdEn,
  input  wire logic [31:0]        regAddr,
  input  wire logic [31:0]        regWrData,
  output logic      [31:0]        regRdData,
  // ordinary data-length selection from line_control
  input  wire logic [1:0]         charLengthSelect,
  output logic      [3:0]         charBits,
  // transmit fifo pop side
  input  wire logic               txFifoValid,
  input  wire unb_pkg::unb_char_s txFifoData,
  output logic                    txFifoPop,
  // transmit shifter
  input  wire logic               txShiftReady,
  output logic                    txCharValid,
  output unb_pkg::unb_char_s      txChar,
  // receiver
  input  wire logic               rxCharValid,
  input  wire unb_pkg::unb_char_s rxChar,
  // receive fifo push side
  output logic                    rxFifoWr,
  output unb_pkg::unb_char_s      rxFifoData
);

  logic               rstMeta_q;   // reset release, first stage
  logic               rstN_q;      // reset release, used everywhere

  // release the reset through two flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstMeta_q <= 1'b0;
      rstN_q    <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstN_q    <= rstMeta_q;
    end
  end

  // register state
  logic [7:0]         rxStation_q, rxStation_d;
  logic [7:0]         txStation_q, txStation_d;
  unb_pkg::unb_ctl_s  ctl_q, ctl_d;
  logic [31:0]        rdData_d;

  // transmit state
  logic               txValid_q, txValid_d;
  unb_pkg::unb_char_s txChar_q, txChar_d;
  logic               addrLoad;    // station character taken now
  logic               dataLoad;    // fifo character taken now
  logic               txFree;      // holding stage can take a char

  // receive state
  logic               rxWr_q, rxWr_d;
  unb_pkg::unb_char_s rxData_q, rxData_d;
  logic               filterOn;
  logic               filterAccept;
  logic               filterHunting;

  logic               wrCtl;       // write to line_ext_control

  assign wrCtl = regWrEn && regAddr == `UNB_LINE_EXT_CONTROL_OFS;

  // transmit choice: the station character goes ahead of fifo data
  always_comb
  begin
    txFree    = !txValid_q || txShiftReady;
    addrLoad  = txFree && ctl_q.nineEn && !ctl_q.txMode
                && ctl_q.sendAddr;
    dataLoad  = txFree && !addrLoad && txFifoValid;
    txFifoPop = dataLoad;
    txValid_d = txValid_q && !txShiftReady;
    txChar_d  = txChar_q;
    if (addrLoad)
    begin
      txValid_d = 1'b1;
      txChar_d  = '{nine: 1'b1, data: txStation_q};
    end
    else if (dataLoad)
    begin
      txValid_d = 1'b1;
      // wide mode keeps the written ninth bit, else it is zero
      txChar_d.nine = ctl_q.nineEn && ctl_q.txMode
                      && txFifoData.nine;
      txChar_d.data = txFifoData.data;
    end
  end

  // register writes and read mux
  always_comb
  begin
    rxStation_d = rxStation_q;
    txStation_d = txStation_q;
    ctl_d       = ctl_q;
    // hardware clears the trigger as the address enters the holding stage
    if (addrLoad)
      ctl_d.sendAddr = 1'b0;
    if (regWrEn)
    begin
      unique case (regAddr)
        `UNB_RX_STATION_ADDRESS_OFS: rxStation_d = regWrData[7:0];
        `UNB_TX_STATION_ADDRESS_OFS: txStation_d = regWrData[7:0];
        `UNB_LINE_EXT_CONTROL_OFS:
        begin
          // a write in the clearing cycle wins: request not lost
          ctl_d.nineEn    = regWrData[`UNB_NINE_BIT_ENABLE_BIT];
          ctl_d.addrMatch = regWrData[`UNB_ADDR_MATCH_BIT];
          ctl_d.sendAddr  = regWrData[`UNB_SEND_ADDRESS_BIT];
          ctl_d.txMode    = regWrData[`UNB_TX_MODE_BIT];
        end
        default: ;   // unmapped writes are dropped
      endcase
    end
    rdData_d = 32'h0000_0000;
    if (regRdEn)
    begin
      unique case (regAddr)
        `UNB_RX_STATION_ADDRESS_OFS: rdData_d = {24'h00_0000, rxStation_q};
        `UNB_TX_STATION_ADDRESS_OFS: rdData_d = {24'h00_0000, txStation_q};
        `UNB_LINE_EXT_CONTROL_OFS:   rdData_d = {28'h000_0000, ctl_q};
        default:                     rdData_d = 32'h0000_0000;
      endcase
    end
  end

  // receive path: filter only with both enables set
  assign filterOn = ctl_q.nineEn && ctl_q.addrMatch;

  unb_addr_filter unb_addr_filter_i
  (
    .clk         (clk),
    .rstN        (rstN_q),
    .enable      (filterOn),
    .stationAddr (rxStation_q),
    .inValid     (rxCharValid),
    .inChar      (rxChar),
    .accept      (filterAccept),
    .hunting     (filterHunting)
  );

  // push accepted characters, ninth bit only in nine-bit mode
  always_comb
  begin
    rxWr_d        = filterAccept;
    rxData_d      = rxData_q;
    if (filterAccept)
    begin
      rxData_d.data = rxChar.data;
      rxData_d.nine = ctl_q.nineEn && rxChar.nine;
    end
  end

  // character length for both directions
  always_comb
  begin
    if (ctl_q.nineEn)
      charBits = `UNB_NINE_BITS;
    else
      charBits = `UNB_BASE_BITS + {2'b00, charLengthSelect};
  end

  // register every group
  always_ff @(posedge clk or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      rxStation_q <= `UNB_STATION_RESET;
      txStation_q <= `UNB_STATION_RESET;
      ctl_q       <= `UNB_CONTROL_RESET;
      regRdData   <= 32'h0000_0000;
      txValid_q   <= 1'b0;
      txChar_q    <= 9'h000;
      rxWr_q      <= 1'b0;
      rxData_q    <= 9'h000;
    end
    else
    begin
      rxStation_q <= rxStation_d;
      txStation_q <= txStation_d;
      ctl_q       <= ctl_d;
      regRdData   <= rdData_d;
      txValid_q   <= txValid_d;
      txChar_q    <= txChar_d;
      rxWr_q      <= rxWr_d;
      rxData_q    <= rxData_d;
    end
  end

  assign txCharValid = txValid_q;
  assign txChar      = txChar_q;
  assign rxFifoWr    = rxWr_q;
  assign rxFifoData  = rxData_q;

  chk_addr_autoclear: assert property (
    @(posedge clk) disable iff (!rstN_q)
    addrLoad && !wrCtl |=> !ctl_q.sendAddr)
    else $error("address trigger not cleared");

  chk_addr_char_nine: assert property (
    @(posedge clk) disable iff (!rstN_q)
    addrLoad |=> txCharValid && txChar.nine
                 && txChar.data == $past(txStation_q))
    else $error("address character wrong");

  chk_data_nine_zero: assert property (
    @(posedge clk) disable iff (!rstN_q)
    dataLoad && !ctl_q.txMode |=> txCharValid && !txChar.nine)
    else $error("eight-bit mode sent ninth bit");

  chk_wide_nine_kept: assert property (
    @(posedge clk) disable iff (!rstN_q)
    dataLoad && ctl_q.txMode && ctl_q.nineEn
    |=> txChar.nine == $past(txFifoData.nine))
    else $error("written ninth bit not sent");

  // watched at the holding stage: an idle fifo must leave it empty
  chk_station_ignored: assert property (
    @(posedge clk) disable iff (!rstN_q)
    (ctl_q.txMode || !ctl_q.nineEn) && txFree && !txFifoValid
    |=> !txCharValid)
    else $error("station address used in wrong mode");

  chk_filter_drop: assert property (
    @(posedge clk) disable iff (!rstN_q)
    rxCharValid && filterOn && (filterHunting || rxChar.nine)
    |=> !rxFifoWr)
    else $error("filtered character stored");

  chk_nofilter_pass: assert property (
    @(posedge clk) disable iff (!rstN_q)
    rxCharValid && ctl_q.nineEn && !ctl_q.addrMatch
    |=> rxFifoWr && rxFifoData == $past(rxChar))
    else $error("unfiltered character lost");

  chk_char_length: assert property (
    @(posedge clk) disable iff (!rstN_q)
    ctl_q.nineEn |-> charBits == 4'h9)
    else $error("nine-bit length not selected");

endmodule

// ### src/unb_params.svh
// constants of the nine-bit multidrop addressing extension
// assumes byte addresses on the register port, 32-bit data words
`ifndef UNB_PARAMS_SVH
`define UNB_PARAMS_SVH

// register byte addresses
`define UNB_RX_STATION_ADDRESS_OFS 32'hb00020c4
`define UNB_TX_STATION_ADDRESS_OFS 32'hb00020c8
`define UNB_LINE_EXT_CONTROL_OFS   32'hb00020cc

// line_ext_control field positions
`define UNB_NINE_BIT_ENABLE_BIT 0
`define UNB_ADDR_MATCH_BIT      1
`define UNB_SEND_ADDRESS_BIT    2
`define UNB_TX_MODE_BIT         3

// reset values
`define UNB_STATION_RESET 8'h00
`define UNB_CONTROL_RESET 4'h0

// character lengths
`define UNB_NINE_BITS    4'h9
`define UNB_BASE_BITS    4'h5

`endif

// ### src/unb_pkg.sv
// types shared by the nine-bit addressing extension
// assumes nothing beyond the params header
package unb_pkg;

  // one serial character: ninth bit and low byte
  typedef struct packed {
    logic       nine;
    logic [7:0] data;
  } unb_char_s;

  // line_ext_control fields, msb first
  typedef struct packed {
    logic txMode;
    logic sendAddr;
    logic addrMatch;
    logic nineEn;
  } unb_ctl_s;

  // receive filter states
  typedef enum logic {
    UNB_HUNT,
    UNB_PASS
  } unb_filt_e;

endpackage

// ### src/unb_addr_filter.sv
// receive station-address filter
// assumes one character per inValid pulse, synchronous reset copy
`include "unb_params.svh"
module unb_addr_filter
(
  input  wire logic              clk,
  input  wire logic              rstN,
  input  wire logic              enable,
  input  wire logic [7:0]        stationAddr,
  input  wire logic              inValid,
  input  wire unb_pkg::unb_char_s inChar,
  output logic                   accept,
  output logic                   hunting
);

  unb_pkg::unb_filt_e state_q;   // match state
  unb_pkg::unb_filt_e state_d;   // next match state

  // decide acceptance and next state
  always_comb
  begin
    state_d = state_q;
    accept  = 1'b0;
    if (!enable)
    begin
      // filter idle: pass all, forget earlier match
      accept  = inValid;
      state_d = unb_pkg::UNB_HUNT;
    end
    else if (inValid && inChar.nine)
    begin
      // address character: compare low byte, not stored
      if (inChar.data == stationAddr)
        state_d = unb_pkg::UNB_PASS;
      else
        state_d = unb_pkg::UNB_HUNT;
    end
    else if (inValid)
    begin
      // data character passes only after a match
      accept = (state_q == unb_pkg::UNB_PASS);
    end
  end

  // register the match state
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      state_q <= unb_pkg::UNB_HUNT;
    else
      state_q <= state_d;
  end

  assign hunting = (state_q == unb_pkg::UNB_HUNT);

  chk_mismatch_hunts: assert property (
    @(posedge clk) disable iff (!rstN)
    enable && inValid && inChar.nine && inChar.data != stationAddr
    |=> hunting)
    else $error("mismatched address did not stop data");

  chk_match_passes: assert property (
    @(posedge clk) disable iff (!rstN)
    enable && inValid && inChar.nine && inChar.data == stationAddr
    ##1 (enable && inValid && !inChar.nine) |-> accept)
    else $error("data after matching address refused");

endmodule

// ### bench/unb_far_side.sv
// far-side model: transmit fifo pop port and the serial shifter
// assumes block outputs settle well before each rising edge
module unb_far_side
(
  input  wire logic               clk,
  input  wire logic               stall,
  input  wire logic               txFifoPop,
  input  wire logic               txCharValid,
  input  wire unb_pkg::unb_char_s txChar,
  output logic                    txFifoValid,
  output unb_pkg::unb_char_s      txFifoData,
  output logic                    txShiftReady
);
  timeunit 1ns;
  timeprecision 1ns;
  unb_pkg::unb_char_s fifoQ[$];  // waiting characters, filled by the bench
  unb_pkg::unb_char_s sentQ[$];  // characters the shifter took
  // drive after the falling edge, sample just before the rising one
  initial
  begin
    txFifoValid  = 1'b0;
    txFifoData   = 9'h000;
    txShiftReady = 1'b1;
    forever
    begin
      @(negedge clk);
      #1;
      txShiftReady = !stall;
      txFifoValid  = fifoQ.size() > 0;
      // empty fifo shows changed data so stale words never pass
      txFifoData   = txFifoValid ? fifoQ[0] : ~txFifoData;
      #23;
      if (txFifoPop === 1'b1 && fifoQ.size() > 0)
        fifoQ.pop_front();
      if (txCharValid === 1'b1 && txShiftReady)
        sentQ.push_back(txChar);
    end
  end
endmodule

// ### bench/unb_nine_bit_bench.sv
// bench for the nine-bit addressing extension over its strobe port
// assumes the far-side model and the design files compile first
`include "unb_params.svh"
module unb_nine_bit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] RXA = `UNB_RX_STATION_ADDRESS_OFS;
  localparam logic [31:0] TXA = `UNB_TX_STATION_ADDRESS_OFS;
  localparam logic [31:0] CTL = `UNB_LINE_EXT_CONTROL_OFS;
  logic               clk = 1'b0;          // 20 MHz
  logic               nrst = 1'b0;
  logic               regWrEn = 1'b0;
  logic               regRdEn = 1'b0;
  logic               rxCharValid = 1'b0;
  logic               stall = 1'b0;        // keeps the shifter busy
  logic [31:0]        regAddr = 32'h0;
  logic [31:0]        regWrData = 32'h0;
  logic [1:0]         charLengthSelect = 2'h0;
  unb_pkg::unb_char_s rxChar = 9'h000;
  logic [31:0]        regRdData;
  logic [3:0]         charBits;
  logic               txFifoValid, txFifoPop, txShiftReady;
  logic               txCharValid, rxFifoWr;
  unb_pkg::unb_char_s txFifoData, txChar, rxFifoData;
  unb_pkg::unb_char_s gotQ[$];             // receive fifo pushes seen
  int                 fails = 0;
  int                 samples_checked = 0;

  always #25 clk = ~clk;

  unb_nine_bit unb_nine_bit_i
  (
    .clk, .nrst, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
    .charLengthSelect, .charBits, .txFifoValid, .txFifoData, .txFifoPop,
    .txShiftReady, .txCharValid, .txChar, .rxCharValid, .rxChar,
    .rxFifoWr, .rxFifoData
  );
  unb_far_side unb_far_side_i
  (
    .clk, .stall, .txFifoPop, .txCharValid, .txChar, .txFifoValid,
    .txFifoData, .txShiftReady
  );

  // push pulse stands one cycle, so look mid-cycle
  always @(negedge clk)
    if (rxFifoWr === 1'b1)
      gotQ.push_back(rxFifoData);

  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(logic [31:0] a, logic [31:0] d);
    @(negedge clk);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask

  // read data is registered, so it is looked at one cycle later
  task automatic rd(logic [31:0] a, logic [31:0] e, string n);
    @(negedge clk);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRdEn = 1'b0;
    chk(n, regRdData, e);
  endtask

  // one character per clock while called back to back
  task automatic rx(unb_pkg::unb_char_s c);
    @(negedge clk);
    rxCharValid = 1'b1;
    rxChar = c;
  endtask

  // released receive data shows the inverse, not the old value
  task automatic rxIdle();
    @(negedge clk);
    rxCharValid = 1'b0;
    rxChar = ~rxChar;
  endtask

  task automatic expectQ(string n, unb_pkg::unb_char_s q[$],
                         logic [8:0] e[$]);
    chk(n, q.size(), e.size());
    foreach (e[i])
      if (i < q.size())
        chk(n, q[i], e[i]);
  endtask

  // bounded wait for the shifter to take n characters
  task automatic waitSent(int n);
    int k;
    k = 0;
    while (unb_far_side_i.sentQ.size() < n && k < 40)
    begin
      @(negedge clk);
      k++;
    end
    if (unb_far_side_i.sentQ.size() < n)
    begin
      fails++;
      $display("BAD txCount expected %0d seen %0d", n,
               unb_far_side_i.sentQ.size());
      end_of_test();
    end
    repeat (4) @(negedge clk);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    // reset values, field widths, an unmapped place
    rd(CTL, 32'h0, "ctlReset");
    rd(TXA, 32'h0, "txReset");
    wr(RXA, 32'hffffff3c);
    rd(RXA, 32'h3c, "rxStation");
    wr(32'hb00020d0, 32'hffffffff);
    rd(32'hb00020d0, 32'h0, "unmapped");
    rd(TXA, 32'h0, "txUntouched");
    wr(CTL, 32'hfffffff0);
    rd(CTL, 32'h0, "ctlHigh");
    $display("test registers done");
    // trigger with the shifter stalled, fifo data queued behind it
    wr(TXA, 32'ha5);
    stall = 1'b1;
    wr(CTL, 32'h5);
    unb_far_side_i.fifoQ.push_back(9'h133);
    rd(CTL, 32'h1, "trigClear");
    chk("txHold", {txCharValid, txChar}, 10'h3a5);
    stall = 1'b0;
    waitSent(2);
    expectQ("txTrig", unb_far_side_i.sentQ, '{9'h1a5, 9'h033});
    unb_far_side_i.sentQ.delete();
    $display("test address trigger done");
    // nine-bit write mode: software marks each character
    wr(CTL, 32'hd);
    unb_far_side_i.fifoQ.push_back(9'h142);
    unb_far_side_i.fifoQ.push_back(9'h017);
    waitSent(2);
    expectQ("txNine", unb_far_side_i.sentQ, '{9'h142, 9'h017});
    rd(CTL, 32'hd, "trigIdle");
    chk("bitsNine", charBits, 4'h9);
    unb_far_side_i.sentQ.delete();
    $display("test nine-bit write done");
    // nine-bit off: trigger idle, ninth bit dropped, normal lengths
    wr(CTL, 32'h0);
    wr(CTL, 32'h4);
    unb_far_side_i.fifoQ.push_back(9'h199);
    waitSent(1);
    expectQ("txEight", unb_far_side_i.sentQ, '{9'h099});
    rd(CTL, 32'h4, "trigOff");
    for (int s = 0; s < 4; s++)
    begin
      @(negedge clk);
      charLengthSelect = s[1:0];
      #1;
      chk("bitsBase", charBits, 4'h5 + 4'(s));
    end
    wr(CTL, 32'h0);
    $display("test eight-bit done");
    // filtering: drop until match, mismatch re-blocks
    wr(CTL, 32'h3);
    rx(9'h011);
    rx(9'h13c);
    rx(9'h022);
    rx(9'h023);
    rx(9'h13d);
    rx(9'h024);
    rx(9'h13c);
    rx(9'h025);
    rxIdle();
    repeat (3) @(negedge clk);
    expectQ("rxFilt", gotQ, '{9'h022, 9'h023, 9'h025});
    gotQ.delete();
    // no filter keeps all; filter without nine-bit has no effect
    wr(CTL, 32'h1);
    rx(9'h13c);
    rx(9'h010);
    rxIdle();
    wr(CTL, 32'h2);
    rx(9'h177);
    rxIdle();
    repeat (3) @(negedge clk);
    expectQ("rxAll", gotQ, '{9'h13c, 9'h010, 9'h077});
    $display("test receive filter done");
    end_of_test();
  end
endmodule
